//--- verilog/ferx_pcs_decode.sv
// Contract
// - Serial recovered bits are gathered into 5-bit code-groups.
// - Plain bit is received scrambled bit XOR local sequence bit.
// - Descrambler locks after 12 consecutive idle groups (11111).
// - Lock starts 722 us hold countdown; 58 idle bits restart it.
// - Countdown expiry without idle content drops lock and reacquires.
// - With descrambler bypassed, alignment takes the NRZ bits directly.
// - Boundary locks on J/K 11000 10001; data framed on that boundary.
// - J/K preceded by idles becomes preamble nibbles 0101 0101.
// - Groups translate to nibbles until T/R or two idle groups.
// - Link Up only after 395 us signal detect; receive needs it.
// - Configuration bit 1 forces signal detect active.
// - Bit 8 adds descrambler lock to entry, not to staying up.
// - Idles followed by non-idle lacking J/K is a bad start.
// - Bad start drives error with nibble 1110 per group until idles.
// - Each bad start adds exactly one to false carrier counter until it saturates at all ones.
// - Bad start is reported once two idle groups follow.
// - Receive chain runs from the 100 MHz system clock; the recovered line clock is sampled.
// - Line bits pass NRZI to NRZ decoding before descrambling.
// - Link pulses never raise Link Up; the signal detect timer clears when they end.
`timescale 1ns/1ps
module ferx_pcs_decode
  import ferx_pkg::*;
#(
  parameter int HOLD_CYCLES   = HOLD_CYCLES_DEF,
  parameter int SIGDET_CYCLES = SIGDET_CYCLES_DEF,
  parameter int FCC_WIDTH     = 16
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             rxClkIn,        // Recovered line clock
  input  wire logic             rxLineBit,      // Recovered NRZI bit
  input  wire logic             sigDetIn,       // Analog signal detect
  input  wire logic             cfgForceSigDet, // Configuration bit 1
  input  wire logic             cfgLockForLink, // Configuration bit 8
  input  wire logic             cfgDescrBypass,
  output ferxMii_t              miiRx,
  output logic                  miiStrobe,
  output logic                  rxCarrier,
  output logic                  linkUp,
  output logic                  descrLocked,
  output logic                  badSsdReport,
  output logic [FCC_WIDTH-1:0]  falseCarrierCnt
);

  // Width of the signal detect timer
  localparam int SDW = $clog2(SIGDET_CYCLES + 1);

  // Parameter sanity
  if (HOLD_CYCLES < 2 || SIGDET_CYCLES < 1 || FCC_WIDTH < 1) begin : gBadParam
    $error("ferx_pcs_decode: unsupported parameter values");
  end

  // Receive framing states
  typedef enum logic [1:0] {
    FS_HUNT,
    FS_CHECK,
    FS_FRAME,
    FS_BAD
  } ferxState_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: clock, data, signal detect
  // Raw, staged and filtered pin levels
  logic [2:0]  pinRaw;
  logic [2:0]  s1_q;
  logic [2:0]  s2_q;
  logic [2:0]  s3_q;
  logic [2:0]  pin_q;
  logic [2:0]  pin_d;
  logic [2:0]  agree;

  assign pinRaw = {sigDetIn, rxLineBit, rxClkIn};
  assign agree  = ~(s2_q ^ s3_q);
  assign pin_d  = (agree & s3_q) | (~agree & pin_q);

  // Three stage capture
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pinRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered levels change once stages two and three agree
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pin_q <= '0;
    else pin_q <= pin_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit strobe and NRZI decoding
  // Bit timing and descrambler hookup
  logic bitStb;
  logic lastLine_q;
  logic nrzBit;
  logic plainBit;
  logic rxBit;
  logic locked;
  logic chainOk;

  assign bitStb = pin_d[0] & ~pin_q[0];
  assign nrzBit = pin_d[1] ^ lastLine_q;

  // Previous line level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lastLine_q <= 1'b0;
    else if (bitStb) lastLine_q <= pin_d[1];
  end

  // Descrambler with its hold timer
  ferx_descrambler #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) uDescr (
    .clock    (clock),
    .nrst     (nrst),
    .bitStb   (bitStb),
    .scrBit   (nrzBit),
    .plainBit (plainBit),
    .locked   (locked)
  );

  // Bypass selects the NRZ stream directly
  assign rxBit       = cfgDescrBypass ? nrzBit : plainBit;
  assign chainOk     = cfgDescrBypass | locked;
  assign descrLocked = locked;

  ////////////////////////////////////////////////////////////////////////////
  // Link integrity monitor
  // Link monitor state
  logic           sigDetEff;
  logic [SDW-1:0] sdCnt_q;
  logic           linkUp_q;

  // Raw pulses shorter than the window never accumulate
  assign sigDetEff = pin_q[2] | cfgForceSigDet;

  // Signal detect qualification timer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) sdCnt_q <= '0;
    else if (!sigDetEff) sdCnt_q <= '0;
    else if (sdCnt_q != SDW'(SIGDET_CYCLES)) sdCnt_q <= sdCnt_q + SDW'(1);
  end

  // Link state: lock gates entry only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) linkUp_q <= 1'b0;
    else if (!sigDetEff) linkUp_q <= 1'b0;
    else if (sdCnt_q == SDW'(SIGDET_CYCLES) && (!cfgLockForLink || chainOk))
      linkUp_q <= 1'b1;
  end

  // Link state to the port
  assign linkUp = linkUp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bit history and idle run
  // Shifted bits and idle run length
  logic [HIST_W-1:0] hist_q;
  logic [HIST_W-1:0] histD;
  logic [3:0]        onesRun_q;
  logic [3:0]        onesRunD;
  logic              lineIdle;
  logic              idlePair;

  assign histD    = {hist_q[HIST_W-2:0], rxBit};
  assign onesRunD = !rxBit ? 4'h0 :
                    (onesRun_q == 4'(IDLE_PAIR_BITS)) ? onesRun_q : onesRun_q + 4'h1;
  assign lineIdle = onesRun_q == 4'(IDLE_PAIR_BITS);
  assign idlePair = onesRunD == 4'(IDLE_PAIR_BITS);

  // Serial to parallel shifter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) hist_q <= '0;
    else if (bitStb) hist_q <= histD;
  end

  // Consecutive ones, saturating at two idle groups
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) onesRun_q <= '0;
    else if (bitStb) onesRun_q <= onesRunD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alignment and decode state machine
  // Framing state, boundary count and output image
  ferxState_t  state_q;
  ferxState_t  stateD;
  logic [2:0]  bitCnt_q;
  logic [2:0]  bitCntD;
  logic        pre2_q;
  logic        pre2D;
  logic        prevT_q;
  logic        prevTD;
  logic        rxEnable;
  logic        groupEnd;
  logic        emit;
  logic        badStart;
  logic        badDone;
  logic [4:0]  group;
  logic [4:0]  grpDec;
  ferxMii_t    miiRx_q;
  ferxMii_t    outD;

  assign rxEnable = linkUp_q & chainOk;
  assign group    = histD[GROUP_BITS-1:0];
  assign grpDec   = ferx_decode5b(group);
  assign groupEnd = bitCnt_q == 3'(GROUP_BITS - 1);

  // Next state and nibble output
  always_comb begin
    stateD   = state_q;
    bitCntD  = bitCnt_q;
    pre2D    = pre2_q;
    prevTD   = prevT_q;
    outD     = miiRx_q;
    emit     = 1'b0;
    badStart = 1'b0;
    badDone  = 1'b0;
    if (!rxEnable) begin
      stateD  = FS_HUNT;
      pre2D   = 1'b0;
      prevTD  = 1'b0;
      outD    = '0;
    end else if (bitStb) begin
      unique case (state_q)
        FS_HUNT: begin
          // First zero after idle starts the delimiter check
          if (lineIdle && !rxBit) begin
            stateD  = FS_CHECK;
            bitCntD = '0;
          end
        end
        FS_CHECK: begin
          bitCntD = bitCnt_q + 3'h1;
          if (bitCnt_q == 3'(JK_TAIL_BITS - 1)) begin
            bitCntD = '0;
            if (histD[9:0] == JK_CODE && histD[14:10] == IDLE_CODE) begin
              stateD = FS_FRAME;
              pre2D  = 1'b1;
              emit   = 1'b1;
              outD   = '{dv: 1'b1, er: 1'b0, nibble: PRE_NIB};
            end else begin
              stateD   = FS_BAD;
              badStart = 1'b1;
              emit     = 1'b1;
              outD     = '{dv: 1'b0, er: 1'b1, nibble: BAD_NIB};
            end
          end
        end
        FS_FRAME: begin
          bitCntD = groupEnd ? 3'h0 : bitCnt_q + 3'h1;
          if (pre2_q) begin
            pre2D = 1'b0;
            emit  = 1'b1;
            outD  = '{dv: 1'b1, er: 1'b0, nibble: PRE_NIB};
          end
          if (idlePair) begin
            stateD = FS_HUNT;
            outD   = '0;
            prevTD = 1'b0;
          end else if (groupEnd) begin
            prevTD = group == T_CODE;
            if (prevT_q && group == R_CODE) begin
              stateD = FS_HUNT;
              outD   = '0;
            end else if (group != T_CODE && group != IDLE_CODE) begin
              emit = 1'b1;
              outD = '{dv: 1'b1, er: !grpDec[4] || prevT_q, nibble: grpDec[3:0]};
            end
          end
        end
        FS_BAD: begin
          bitCntD = groupEnd ? 3'h0 : bitCnt_q + 3'h1;
          if (idlePair) begin
            stateD  = FS_HUNT;
            badDone = 1'b1;
            outD    = '0;
          end else if (groupEnd) begin
            emit = 1'b1;
            outD = '{dv: 1'b0, er: 1'b1, nibble: BAD_NIB};
          end
        end
      endcase
    end
  end

  // State, boundary counter and pair flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q  <= FS_HUNT;
      bitCnt_q <= '0;
      pre2_q   <= 1'b0;
      prevT_q  <= 1'b0;
    end else begin
      state_q  <= stateD;
      bitCnt_q <= bitCntD;
      pre2_q   <= pre2D;
      prevT_q  <= prevTD;
    end
  end

  // Registered nibble interface
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      miiRx_q   <= '0;
      miiStrobe <= 1'b0;
    end else begin
      miiRx_q   <= outD;
      miiStrobe <= emit;
    end
  end

  // Nibble interface straight from its register
  assign miiRx = miiRx_q;

  // Carrier present outside hunt
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rxCarrier <= 1'b0;
    else rxCarrier <= stateD != FS_HUNT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // False carrier counting and reporting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) falseCarrierCnt <= '0;
    else if (badStart && falseCarrierCnt != '1)
      falseCarrierCnt <= falseCarrierCnt + FCC_WIDTH'(1);
  end

  // One cycle report once idles follow the bad start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) badSsdReport <= 1'b0;
    else badSsdReport <= badDone;
  end

endmodule : ferx_pcs_decode

//--- verilog/ferx_pkg.sv
package ferx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ           = 100;
  localparam int HOLD_TIME_US      = 722;
  localparam int SIGDET_TIME_US    = 395;
  localparam int HOLD_CYCLES_DEF   = HOLD_TIME_US * CLK_MHZ;
  localparam int SIGDET_CYCLES_DEF = SIGDET_TIME_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Code-group layout
  localparam int GROUP_BITS       = 5;
  localparam int LOCK_IDLE_GROUPS = 12;
  localparam int LOCK_BITS        = LOCK_IDLE_GROUPS * GROUP_BITS;
  localparam int HOLD_IDLE_BITS   = 58;
  localparam int IDLE_PAIR_BITS   = 2 * GROUP_BITS;
  localparam int JK_TAIL_BITS     = 7;
  localparam int RUN_W            = $clog2(LOCK_BITS + 1);
  localparam int HIST_W           = 3 * GROUP_BITS;

  localparam logic [4:0] IDLE_CODE = 5'h1f;
  localparam logic [9:0] JK_CODE   = 10'h311;
  localparam logic [4:0] T_CODE    = 5'h0d;
  localparam logic [4:0] R_CODE    = 5'h07;
  localparam logic [3:0] PRE_NIB   = 4'h5;
  localparam logic [3:0] BAD_NIB   = 4'he;

  ////////////////////////////////////////////////////////////////////////////
  // Scrambler sequence generator
  localparam int LFSR_LEN = 11;
  localparam int TAP_A    = 10;
  localparam int TAP_B    = 8;

  // Nibble interface toward the MAC
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] nibble;
  } ferxMii_t;

  // Code-group to {valid, nibble}
  function automatic logic [4:0] ferx_decode5b(input logic [4:0] code);
    case (code)
      5'h1e:   return {1'b1, 4'h0};
      5'h09:   return {1'b1, 4'h1};
      5'h14:   return {1'b1, 4'h2};
      5'h15:   return {1'b1, 4'h3};
      5'h0a:   return {1'b1, 4'h4};
      5'h0b:   return {1'b1, 4'h5};
      5'h0e:   return {1'b1, 4'h6};
      5'h0f:   return {1'b1, 4'h7};
      5'h12:   return {1'b1, 4'h8};
      5'h13:   return {1'b1, 4'h9};
      5'h16:   return {1'b1, 4'ha};
      5'h17:   return {1'b1, 4'hb};
      5'h1a:   return {1'b1, 4'hc};
      5'h1b:   return {1'b1, 4'hd};
      5'h1c:   return {1'b1, 4'he};
      5'h1d:   return {1'b1, 4'hf};
      default: return {1'b0, BAD_NIB};
    endcase
  endfunction : ferx_decode5b

endpackage : ferx_pkg

//--- verilog/ferx_descrambler.sv
`timescale 1ns/1ps
module ferx_descrambler
  import ferx_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic bitStb,
  input  wire logic scrBit,
  output logic      plainBit,
  output logic      locked
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);

  // Parameter sanity: expiry is taken at a count of one
  if (HOLD_CYCLES < 2) begin : gBadHold
    $error("ferx_descrambler: unsupported hold count");
  end

  logic [LFSR_LEN-1:0] lfsr_q;
  logic [RUN_W-1:0]    match_q;
  logic [RUN_W-1:0]    ones_q;
  logic [HW-1:0]       hold_q;
  logic                locked_q;
  logic                keyBit;
  logic                idleSeen;
  logic                expire;
  logic                gainLock;

  // Local sequence bit and plain output
  assign keyBit   = lfsr_q[TAP_A] ^ lfsr_q[TAP_B];
  assign plainBit = scrBit ^ keyBit;
  assign locked   = locked_q;
  assign idleSeen = bitStb && plainBit && (ones_q == RUN_W'(HOLD_IDLE_BITS - 1));
  assign expire   = locked_q && !idleSeen && (hold_q == HW'(1));
  assign gainLock = !locked_q && bitStb && (~scrBit == keyBit)
                    && (match_q == RUN_W'(LOCK_BITS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Generator: loaded from line during acquisition, free running once locked
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lfsr_q <= '0;
    else if (bitStb) lfsr_q <= {lfsr_q[LFSR_LEN-2:0], locked_q ? keyBit : ~scrBit};
  end

  // Consecutive correctly predicted idle bits
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) match_q <= '0;
    else if (locked_q || expire) match_q <= '0;
    else if (bitStb) match_q <= (~scrBit == keyBit) ? match_q + RUN_W'(1) : '0;
  end

  // Lock flag
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) locked_q <= 1'b0;
    else if (gainLock) locked_q <= 1'b1;
    else if (expire) locked_q <= 1'b0;
  end

  // Idle content run while locked
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) ones_q <= '0;
    else if (!locked_q || idleSeen) ones_q <= '0;
    else if (bitStb) ones_q <= plainBit ? ones_q + RUN_W'(1) : '0;
  end

  // Hold timer countdown, restarted by idle content
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) hold_q <= '0;
    else if (gainLock || idleSeen) hold_q <= HW'(HOLD_CYCLES);
    else if (locked_q && hold_q != '0) hold_q <= hold_q - HW'(1);
  end

endmodule : ferx_descrambler

//--- sim/ferx_pcs_decode_chk.sv
`timescale 1ns/1ps
module ferx_pcs_decode_chk
  import ferx_pkg::*;
#(
  parameter int HOLD_CYCLES   = HOLD_CYCLES_DEF,
  parameter int SIGDET_CYCLES = SIGDET_CYCLES_DEF,
  parameter int FCC_WIDTH     = 16
) (
  input wire logic                 clock,
  input wire logic                 nrst,
  input wire logic                 sigDetIn,
  input wire logic                 cfgForceSigDet,
  input wire logic                 cfgLockForLink,
  input wire ferxMii_t             miiRx,
  input wire logic                 miiStrobe,
  input wire logic                 rxCarrier,
  input wire logic                 linkUp,
  input wire logic                 descrLocked,
  input wire logic                 badSsdReport,
  input wire logic [FCC_WIDTH-1:0] falseCarrierCnt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Run length of pin-level signal detect
  logic [31:0] hiCnt_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) hiCnt_q <= 32'h0000_0000;
    else if (!(sigDetIn | cfgForceSigDet)) hiCnt_q <= 32'h0000_0000;
    else if (hiCnt_q < 32'h0010_0000) hiCnt_q <= hiCnt_q + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nibble shapes
  sequence badStrobe_s;
    miiStrobe && miiRx.er && !miiRx.dv;
  endsequence
  sequence preStrobe_s;
    miiStrobe && miiRx.dv && !miiRx.er && miiRx.nibble == PRE_NIB;
  endsequence

  reset_clear_a: assert property (!$past(nrst) |-> !miiStrobe && !linkUp && falseCarrierCnt == '0)
    else $error("outputs not clear after reset");
  link_entry_a: assert property ($rose(linkUp) |-> hiCnt_q >= SIGDET_CYCLES)
    else $error("link up too early");
  link_timely_a: assert property (hiCnt_q == SIGDET_CYCLES + 8 && !cfgLockForLink |-> linkUp)
    else $error("link up too late");
  link_drop_a: assert property ((!sigDetIn && !cfgForceSigDet) [*6] |-> !linkUp)
    else $error("link held without signal detect");
  lock_entry_a: assert property ($rose(linkUp) && cfgLockForLink |-> $past(descrLocked))
    else $error("link up without lock");
  strobe_pulse_a: assert property (miiStrobe |=> !miiStrobe [*4])
    else $error("nibble strobes too close");
  preamble_pair_a: assert property ($rose(miiRx.dv) && miiStrobe |-> preStrobe_s ##[4:12] preStrobe_s)
    else $error("preamble pair missing");
  bad_nibble_a: assert property (badStrobe_s |-> miiRx.nibble == BAD_NIB)
    else $error("bad start nibble wrong");
  fcc_step_a: assert property ($changed(falseCarrierCnt) |->
    falseCarrierCnt == $past(falseCarrierCnt) + 1'b1 && miiStrobe && miiRx.er && !miiRx.dv)
    else $error("false carrier count step wrong");
  report_once_a: assert property (badSsdReport |=> !badSsdReport && !miiRx.er)
    else $error("bad start report not a clean pulse");
  refuse_a: assert property ((!linkUp) [*2] |-> !miiStrobe && !rxCarrier)
    else $error("receive active without link");
endmodule : ferx_pcs_decode_chk

bind ferx_pcs_decode ferx_pcs_decode_chk #(
  .HOLD_CYCLES(HOLD_CYCLES), .SIGDET_CYCLES(SIGDET_CYCLES), .FCC_WIDTH(FCC_WIDTH)
) chk (
  .clock(clock), .nrst(nrst), .sigDetIn(sigDetIn), .cfgForceSigDet(cfgForceSigDet),
  .cfgLockForLink(cfgLockForLink), .miiRx(miiRx), .miiStrobe(miiStrobe), .rxCarrier(rxCarrier),
  .linkUp(linkUp), .descrLocked(descrLocked), .badSsdReport(badSsdReport), .falseCarrierCnt(falseCarrierCnt)
);

//--- sim/ferx_line_model.sv
`timescale 1ns/1ps
module ferx_line_model
  import ferx_pkg::*;
(
  input  wire logic run,
  input  wire logic scrOn,
  output logic      rxClkIn,
  output logic      rxLineBit
);
  logic        bitQ [$];
  logic [10:0] scr_q;
  logic        nrz;

  // Queue one code-group, first bit sent is the MSB
  task automatic push(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) bitQ.push_back(g[i]);
  endtask : push

  ////////////////////////////////////////////////////////////////////////////
  // Line clock of 80 ns, data moves at the falling edge
  initial begin
    rxClkIn   = 1'b0;
    rxLineBit = 1'b0;
    scr_q     = 11'h7ff;
    forever begin
      #40 rxClkIn = 1'b0;
      if (run) begin
        nrz = (bitQ.size() != 0) ? bitQ.pop_front() : 1'b1; // Idle when empty
        if (scrOn) nrz = nrz ^ scr_q[10] ^ scr_q[8];
        scr_q = {scr_q[9:0], scr_q[10] ^ scr_q[8]};
        rxLineBit = rxLineBit ^ nrz;
      end else begin
        rxLineBit = ~rxLineBit;                               // No carrier, noise
      end
      #40 rxClkIn = run;
    end
  end
endmodule : ferx_line_model

//--- sim/fast_ethernet_rx_pcs_decode_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
`define WAITFOR(c, lim) begin k = 0; while (!(c) && k < (lim)) begin @(negedge clock); k++; end \
  if (!(c)) begin n_mismatch++; complete_run(); end end
module fast_ethernet_rx_pcs_decode_tb;
  import ferx_pkg::*;
  localparam int HOLD = 2000;
  localparam int SIGD = 50;
  logic        clock, nrst, sigDetIn, cfgForceSigDet, cfgLockForLink, cfgDescrBypass;
  logic        run, scrOn, rxClkIn, rxLineBit, miiStrobe, rxCarrier, linkUp, descrLocked, badSsdReport;
  ferxMii_t    miiRx;
  logic [15:0] falseCarrierCnt, expFcc;
  logic [31:0] lfsr_q;
  logic [5:0]  ex;
  logic [5:0]  expQ [$];
  logic [4:0]  enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  int          n_mismatch, cmp_count, mode, nBad, k;

  ferx_line_model line (.run(run), .scrOn(scrOn), .rxClkIn(rxClkIn), .rxLineBit(rxLineBit));
  ferx_pcs_decode #(.HOLD_CYCLES(HOLD), .SIGDET_CYCLES(SIGD), .FCC_WIDTH(16)) dut (
    .clock(clock), .nrst(nrst), .rxClkIn(rxClkIn), .rxLineBit(rxLineBit), .sigDetIn(sigDetIn),
    .cfgForceSigDet(cfgForceSigDet), .cfgLockForLink(cfgLockForLink), .cfgDescrBypass(cfgDescrBypass),
    .miiRx(miiRx), .miiStrobe(miiStrobe), .rxCarrier(rxCarrier), .linkUp(linkUp),
    .descrLocked(descrLocked), .badSsdReport(badSsdReport), .falseCarrierCnt(falseCarrierCnt));

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Strobed nibbles against the expected stream in mode 0 and the bad nibble in mode 1
  always @(negedge clock) begin
    if (miiStrobe === 1'b1 && mode == 1) begin
      nBad++;
      `CHK(miiRx, {2'b01, BAD_NIB})
    end else if (miiStrobe === 1'b1 && mode == 0) begin
      ex = (expQ.size() != 0) ? expQ.pop_front() : 6'h00;
      `CHK(miiRx, ex)
    end
  end

  // One frame of random nibbles with its expected image
  task automatic send_frame(input int n);
    logic [3:0] d;
    repeat (4) line.push(IDLE_CODE);
    line.push(JK_CODE[9:5]);
    line.push(JK_CODE[4:0]);
    repeat (2) expQ.push_back({2'b10, PRE_NIB});
    repeat (n) begin
      lfsr_q = lfsr_next(lfsr_q);
      d = lfsr_q[3:0];
      line.push(enc[d]);
      expQ.push_back({2'b10, d});
    end
    line.push(T_CODE);
    line.push(R_CODE);
    repeat (4) line.push(IDLE_CODE);
    `WAITFOR(line.bitQ.size() == 0, 20000)
    repeat (200) @(negedge clock);
    `CHK(expQ.size(), 0)
    `CHK(miiRx.dv, 1'b0)
  endtask : send_frame

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst, sigDetIn, cfgForceSigDet, cfgLockForLink, run, scrOn} = 6'h00;
    cfgDescrBypass = 1'b1;
    {mode, nBad, n_mismatch, cmp_count} = '0;
    expFcc = 16'h0000;
    lfsr_q = 32'h0000_bd1c;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    `CHK(falseCarrierCnt, expFcc)
    sigDetIn = 1'b1;
    `WAITFOR(linkUp, 200)
    `CHK(k >= SIGD, 1'b1)
    sigDetIn = 1'b0;
    `WAITFOR(!linkUp, 20)
    cfgForceSigDet = 1'b1;
    `WAITFOR(linkUp, 200)
    `CHK(linkUp, 1'b1)
    cfgForceSigDet = 1'b0;
    `WAITFOR(!linkUp, 20)
    $display("test link done");
    {cfgLockForLink, cfgForceSigDet, cfgDescrBypass} = 3'h6;
    repeat (150) @(negedge clock);
    `CHK(linkUp, 1'b0)
    {run, scrOn} = 2'h3;
    `WAITFOR(descrLocked, 2000)
    `CHK(descrLocked, 1'b1)
    `WAITFOR(linkUp, 200)
    `CHK(linkUp, 1'b1)
    $display("test lock done");
    for (int f = 0; f < 3; f++) send_frame(4 + 6 * f);
    `CHK(descrLocked, 1'b1)
    $display("test frames done");
    mode = 1;
    repeat (3) line.push(5'h0a);
    expFcc = expFcc + 16'h0001;
    `WAITFOR(badSsdReport, 2000)
    @(negedge clock);
    mode = 0;
    `CHK(nBad >= 3, 1'b1)
    `CHK(falseCarrierCnt, expFcc)
    `CHK(miiRx, 6'h00)
    $display("test bad start done");
    mode = 2;
    line.push(JK_CODE[9:5]);
    line.push(JK_CODE[4:0]);
    repeat (70) line.push(enc[4'h6]);
    `WAITFOR(!descrLocked, 6000)
    `CHK(linkUp, 1'b1)
    repeat (3) @(negedge clock);
    `CHK(miiRx, 6'h00)
    `WAITFOR(line.bitQ.size() == 0, 6000)
    `WAITFOR(descrLocked, 3000)
    `CHK(descrLocked, 1'b1)
    mode = 0;
    $display("test hold expiry done");
    // Link down while the line drops scrambling
    cfgForceSigDet = 1'b0;
    `WAITFOR(!linkUp, 20)
    {scrOn, cfgDescrBypass, cfgLockForLink} = 3'h2;
    repeat (200) @(negedge clock);
    cfgForceSigDet = 1'b1;
    `WAITFOR(linkUp, 200)
    send_frame(8);
    `CHK(falseCarrierCnt, expFcc)
    $display("test bypass done");
    complete_run();
  end
endmodule : fast_ethernet_rx_pcs_decode_tb
